// File: pkg/pid_pkg.sv
package pid_pkg;
   // Address space
   localparam int ADDR_W = 24;
   localparam int DATA_W = 24;
   localparam logic [23:0] IO_BASE = 24'hFF_FF80;
   localparam int IO_WORDS = 128;
   // Internal I/O register word indices (low seven address bits)
   localparam logic [6:0] IDX_HOST_CTRL = 7'h42;
   localparam logic [6:0] IDX_HOST_STAT = 7'h43;
   localparam logic [6:0] IDX_PRIO = 7'h7E;
   // Host control bits
   localparam int CTRL_RX_IE = 0;
   localparam int CTRL_TX_IE = 1;
   localparam int CTRL_HF_IE = 2;
   localparam int CTRL_HF_CODE_LO = 3;
   // Host status bits
   localparam int STAT_RX_FULL = 0;
   localparam int STAT_TX_EMPTY = 1;
   localparam int STAT_HF_LO = 3;
   // Core status word global enable bit (mode byte)
   localparam int STATUS_WORD_GIE_BIT = 8;
   // Vectors
   localparam logic [23:0] VEC_HOST_RX = 24'h00_0060;
   localparam logic [23:0] VEC_HOST_TX = 24'h00_0062;
   localparam logic [23:0] VEC_HOST_HF = 24'h00_0064;
   localparam int NSRC = 3;
   localparam int SHORT_OPS = 2;
   localparam logic [23:0] RESET_VAL = 24'h00_0000;
   typedef enum logic [1:0] {ST_RUN, ST_SHORT, ST_LONG} svc_state_t;
endpackage : pid_pkg

// File: logic/peripheral_interrupt_dispatch.sv
// How it works
// - Registers decode only in the top 128 words of X data space.
// - Host status register is read-only; writes never change it.
// - A set receive or transmit status bit raises a request while that source is enabled.
// - Two host-written flag bits raise an interrupt on a programmed encoding.
// - Each interrupt fires from the very status flag software polls.
// - Accepting an interrupt redirects fetch to the source's fixed vector.
// - Two-opcode short service returns automatically without return op.
// - Jump-to-subroutine service runs until return op, then resumes saved PC.
// - Request needs source enable in control reg and enable in priority reg.
// - Requests masked unless global enable in core mode byte is set.
// - Peripheral offers three sources, each with own vector.
// - Host receive vectors to $60, gated by host receive enable bit.
// - Bit 1 of host status is transmit-empty, set when word accepted.
module peripheral_interrupt_dispatch #(
   parameter int NSRC = pid_pkg::NSRC
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic [23:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [23:0] i_wdata,
   output logic [23:0] o_rdata,
   output logic o_io_sel,
   input wire logic i_rx_full,
   input wire logic i_tx_empty,
   input wire logic [1:0] i_host_flags,
   input wire logic [23:0] i_core_status_word,
   input wire logic i_fetch,
   input wire logic [23:0] i_pc,
   input wire logic i_jump_to_subroutine_op,
   input wire logic i_return_from_interrupt_op,
   output logic o_irq_take,
   output logic [23:0] o_vector,
   output logic o_return,
   output logic [23:0] o_return_pc,
   output logic o_in_service
);
   logic [23:0] host_control_reg_r;
   logic [23:0] periph_priority_reg_r;
   logic [1:0] rx_s1_r, rx_s2_r;
   logic [1:0] tx_s1_r, tx_s2_r;
   logic [1:0] hf_s1_r, hf_s2_r;
   pid_pkg::svc_state_t state_r, state_nxt;
   logic [23:0] saved_pc_r;
   logic [1:0] short_cnt_r;
   logic [1:0] cur_src_r;

   // Pin synchronisers
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         rx_s1_r <= '0;
         rx_s2_r <= '0;
         tx_s1_r <= '0;
         tx_s2_r <= '0;
         hf_s1_r <= '0;
         hf_s2_r <= '0;
      end
      else
      begin
         rx_s1_r <= {1'b0, i_rx_full};
         rx_s2_r <= rx_s1_r;
         tx_s1_r <= {1'b0, i_tx_empty};
         tx_s2_r <= tx_s1_r;
         hf_s1_r <= i_host_flags;
         hf_s2_r <= hf_s1_r;
      end
   end

   // Address decode
   // top 128 words
   wire io_hit = (i_addr[23:7] == pid_pkg::IO_BASE[23:7]);
   wire [6:0] idx = i_addr[6:0];
   wire wr_host_ctrl = i_wr && io_hit && (idx == pid_pkg::IDX_HOST_CTRL);
   wire wr_prio = i_wr && io_hit && (idx == pid_pkg::IDX_PRIO);
   assign o_io_sel = io_hit && (i_wr || i_rd);

   // Host status word, built live from the flags
   // transmit-empty in bit 1
   wire [23:0] host_status_reg = {19'h0_0000, hf_s2_r, 1'b0, tx_s2_r[0], rx_s2_r[0]};

   // Control registers; status writes have no target
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         host_control_reg_r <= pid_pkg::RESET_VAL;
         periph_priority_reg_r <= pid_pkg::RESET_VAL;
      end
      else
      begin
         if (wr_host_ctrl)
            host_control_reg_r <= i_wdata;
         if (wr_prio)
            periph_priority_reg_r <= i_wdata;
      end
   end

   // Read mux
   wire [23:0] rd_mux = !io_hit ? 24'h00_0000 :
      (idx == pid_pkg::IDX_HOST_CTRL) ? host_control_reg_r :
      (idx == pid_pkg::IDX_HOST_STAT) ? host_status_reg :
      (idx == pid_pkg::IDX_PRIO) ? periph_priority_reg_r : 24'h00_0000;
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         o_rdata <= '0;
      else if (i_rd)
         o_rdata <= rd_mux;
   end

   // Source requests from polled flags
   // status flags raise requests; same flags as polling
   wire hf_match = (hf_s2_r == host_control_reg_r[pid_pkg::CTRL_HF_CODE_LO +: 2]);
   wire [NSRC-1:0] flag = {hf_match, tx_s2_r[0], rx_s2_r[0]};
   wire [NSRC-1:0] src_en = {host_control_reg_r[pid_pkg::CTRL_HF_IE],
                             host_control_reg_r[pid_pkg::CTRL_TX_IE],
                             host_control_reg_r[pid_pkg::CTRL_RX_IE]};
   // three host sources, each with its own vector
   wire [23:0] vec_tab [NSRC];
   assign vec_tab[0] = pid_pkg::VEC_HOST_RX;
   assign vec_tab[1] = pid_pkg::VEC_HOST_TX;
   assign vec_tab[2] = pid_pkg::VEC_HOST_HF;
   wire [1:0] lvl [NSRC];
   wire [NSRC-1:0] req;
   // global enable in core mode byte
   wire gie = i_core_status_word[pid_pkg::STATUS_WORD_GIE_BIT];
   genvar g;
   generate
      for (g = 0; g < NSRC; g++)
      begin : g_src
         assign lvl[g] = periph_priority_reg_r[2*g +: 2];
         // source enable and nonzero priority level; either bit set
         assign req[g] = flag[g] && src_en[g] && (lvl[g] != 2'b00) && gie;
      end
   endgenerate

   // pick highest level, lowest index on tie
   logic [1:0] win;
   logic [1:0] win_lvl;
   always_comb
   begin
      win = 2'd0;
      win_lvl = 2'd0;
      for (int k = 0; k < NSRC; k++)
         if (req[k] && (lvl[k] > win_lvl))
         begin
            win = 2'(k);
            win_lvl = lvl[k];
         end
   end
   wire any_req = |req;

   // Service state machine
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         pid_pkg::ST_RUN:
            if (any_req && i_fetch)
               state_nxt = pid_pkg::ST_SHORT;
         pid_pkg::ST_SHORT:
            // jump op in slot makes it long
            if (i_fetch && i_jump_to_subroutine_op)
               state_nxt = pid_pkg::ST_LONG;
            else if (i_fetch && short_cnt_r == 2'(pid_pkg::SHORT_OPS - 1))
               state_nxt = pid_pkg::ST_RUN;
         pid_pkg::ST_LONG:
            if (i_fetch && i_return_from_interrupt_op)
               state_nxt = pid_pkg::ST_RUN;
         default:
            state_nxt = pid_pkg::ST_RUN;
      endcase
   end

   // take interrupt at fetch and vector
   assign o_irq_take = (state_r == pid_pkg::ST_RUN) && any_req && i_fetch;
   // auto return after two ops; return on return op
   assign o_return = (state_r != pid_pkg::ST_RUN) && (state_nxt == pid_pkg::ST_RUN);
   assign o_in_service = (state_r != pid_pkg::ST_RUN);

   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         state_r <= pid_pkg::ST_RUN;
         saved_pc_r <= '0;
         short_cnt_r <= '0;
         cur_src_r <= '0;
         o_vector <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         if (o_irq_take)
         begin
            saved_pc_r <= i_pc;
            cur_src_r <= win;
            o_vector <= vec_tab[win];
            short_cnt_r <= '0;
         end
         else if (state_r == pid_pkg::ST_SHORT && i_fetch)
            short_cnt_r <= short_cnt_r + 2'd1;
      end
   end
   assign o_return_pc = saved_pc_r;

   chk_vector_taken: assert property (@(posedge i_clk) disable iff (!i_nrst)
      o_irq_take |=> o_vector == vec_tab[$past(win)])
      else $error("vector wrong");
   // short service ends after two fetches
   sequence s_two_fetch;
      (i_fetch && !i_jump_to_subroutine_op) ##1 (i_fetch && !i_jump_to_subroutine_op);
   endsequence
   chk_short_return: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (o_irq_take ##1 s_two_fetch) |-> o_return)
      else $error("short service did not return");
   chk_long_return: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (state_r == pid_pkg::ST_LONG && i_fetch && i_return_from_interrupt_op) |-> o_return && o_return_pc == saved_pc_r)
      else $error("return op missed");
   chk_gie_mask: assert property (@(posedge i_clk) disable iff (!i_nrst)
      !gie |-> !o_irq_take)
      else $error("masked take");
   chk_src_enable: assert property (@(posedge i_clk) disable iff (!i_nrst)
      o_irq_take |-> |(src_en & flag))
      else $error("disabled source taken");
   chk_status_ro: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_wr && io_hit && idx == pid_pkg::IDX_HOST_STAT) |=> host_control_reg_r == $past(host_control_reg_r))
      else $error("status write changed state");
   chk_rx_vector: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (o_irq_take && win == 2'd0) |=> o_vector == pid_pkg::VEC_HOST_RX)
      else $error("rx vector");
   chk_tx_bit: assert property (@(posedge i_clk) disable iff (!i_nrst)
      $past(i_nrst, 2) |-> host_status_reg[pid_pkg::STAT_TX_EMPTY] == $past(i_tx_empty, 2))
      else $error("tx empty bit");
   // Requests that would outrank the chosen source
   wire [NSRC-1:0] outranked;
   genvar h;
   generate
      for (h = 0; h < NSRC; h++)
      begin : g_rank
         assign outranked[h] = req[h] && (lvl[h] > lvl[win]);
      end
   endgenerate
   chk_prio_win: assert property (@(posedge i_clk) disable iff (!i_nrst)
      o_irq_take |-> req[win] && !(|outranked))
      else $error("priority");
endmodule : peripheral_interrupt_dispatch

// File: dv/core_model.sv
module core_model #(
   parameter int LONG_LEN = 4
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_fetch,
   input wire logic i_long,
   input wire logic i_take,
   input wire logic i_ret,
   input wire logic [23:0] i_vector,
   input wire logic [23:0] i_ret_pc,
   output logic [23:0] o_pc,
   output logic o_jump_to_subroutine_op,
   output logic o_return_from_interrupt_op
);
   timeunit 1ns;
   timeprecision 1ps;
   int svc_r;
   logic [23:0] pc_r;
   // first service fetch comes from the vector
   assign o_pc = (svc_r == 1) ? i_vector : pc_r;
   // long service opens with a subroutine jump, ends with a return
   assign o_jump_to_subroutine_op = i_long && (svc_r == 1);
   assign o_return_from_interrupt_op = i_long && (svc_r == LONG_LEN);
   // Service depth and program counter, advanced once per fetch
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         svc_r <= 0;
         pc_r <= 24'h00_0100;
      end
      else if (i_fetch)
      begin
         svc_r <= i_ret ? 0 : (i_take || svc_r != 0) ? svc_r + 1 : 0;
         pc_r <= i_ret ? i_ret_pc : o_pc + 24'h00_0001;
      end
   end
endmodule : core_model

// File: dv/peripheral_interrupt_dispatch_test.sv
module peripheral_interrupt_dispatch_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LONG_LEN = 4;
   localparam logic [23:0] CTRL_A = pid_pkg::IO_BASE | 24'(pid_pkg::IDX_HOST_CTRL);
   localparam logic [23:0] STAT_A = pid_pkg::IO_BASE | 24'(pid_pkg::IDX_HOST_STAT);
   localparam logic [23:0] PRIO_A = pid_pkg::IO_BASE | 24'(pid_pkg::IDX_PRIO);
   logic clk = 0, nrst = 0, wr = 0, rd = 0, rx = 0, tx = 0, fetch = 0, long_svc = 0;
   logic [1:0] fl = 2'b00, code;
   logic [23:0] addr = 24'h00_0000, wdata = 24'h00_0000, sw = 24'h00_0000;
   logic [23:0] rdata, pc, vec, ret_pc;
   logic io_sel, jump_op, ret_op, take, ret, in_svc;
   logic [4:0] v;
   logic [31:0] lfsr_r = 32'h8d10_dc5c;
   int error_cnt = 0, compares = 0, i;
   // Clock and the two ends
   always #4 clk = ~clk;
   peripheral_interrupt_dispatch peripheral_interrupt_dispatch_inst (
      .i_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wr(wr), .i_rd(rd), .i_wdata(wdata), .o_rdata(rdata),
      .o_io_sel(io_sel), .i_rx_full(rx), .i_tx_empty(tx), .i_host_flags(fl), .i_core_status_word(sw),
      .i_fetch(fetch), .i_pc(pc), .i_jump_to_subroutine_op(jump_op), .i_return_from_interrupt_op(ret_op),
      .o_irq_take(take), .o_vector(vec),
      .o_return(ret), .o_return_pc(ret_pc), .o_in_service(in_svc));
   core_model #(.LONG_LEN(LONG_LEN)) core_model_inst (
      .i_clk(clk), .i_nrst(nrst), .i_fetch(fetch), .i_long(long_svc), .i_take(take), .i_ret(ret),
      .i_vector(vec), .i_ret_pc(ret_pc), .o_pc(pc), .o_jump_to_subroutine_op(jump_op),
      .o_return_from_interrupt_op(ret_op));
   // Pseudo random source
   function automatic logic [31:0] rnd();
      lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
      return lfsr_r;
   endfunction : rnd
   // Reference model: vector of the winning source, or -1
   function automatic int exp_vec(logic [4:0] c, logic [5:0] p, logic g, logic r, logic t, logic [1:0] f);
      int best;
      int bp;
      logic [2:0] req;
      best = -1;
      bp = 0;
      req = {c[2] && f == c[4:3], c[1] && t, c[0] && r};
      for (int s = 0; s < 3; s++)
         if (g && req[s] && p[2*s+:2] > bp)
         begin
            best = s;
            bp = p[2*s+:2];
         end
      return best < 0 ? -1 : 'h60 + 2 * best;
   endfunction : exp_vec
   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // One register access, strobe held for one edge
   task automatic acc(input logic w, input logic [23:0] a, input logic [23:0] d);
      @(posedge clk) #1;
      addr = a;
      wdata = d;
      wr = w;
      rd = !w;
      #1 chk("io select", {23'h0, &a[23:7]}, {23'h0, io_sel});
      @(posedge clk) #1;
      wr = 0;
      rd = 0;
   endtask : acc
   // Configure, let flags settle, fetch, and follow the service
   task automatic try_irq(input logic [4:0] c, input logic [5:0] p, input logic g, input logic r,
                          input logic t, input logic [1:0] f, input logic lng);
      int e;
      int n;
      logic [23:0] p0;
      acc(1, PRIO_A, 24'h00_0000); // disable before configuring
      acc(1, CTRL_A, {19'h0, c}); // only written outside a service
      acc(1, PRIO_A, {18'h0, p}); // enable once configured
      sw = {15'(rnd()), g, 8'(rnd())};
      rx = r;
      tx = t;
      fl = f;
      long_svc = lng;
      e = exp_vec(c, p, g, r, t, f);
      repeat (3) @(posedge clk);
      #1;
      fetch = 1;
      for (n = 1; n <= 8; n++)
      begin
         @(negedge clk);
         if (take === 1'b1)
            break;
      end
      chk("irq taken", {23'h0, e >= 0}, {23'h0, n <= 8});
      p0 = pc;
      if (e >= 0 && n <= 8)
      begin
         @(negedge clk);
         chk("vector", 24'(e), vec);
         chk("in service", 24'h00_0001, {23'h0, in_svc});
         for (n = 1; n < 12 && ret !== 1'b1; n++)
            @(negedge clk);
         chk("service length", 24'(lng ? LONG_LEN : 2), 24'(n));
         chk("return pc", p0, ret_pc);
      end
      @(posedge clk) #1;
      fetch = 0;
      chk("service over", 24'h00_0000, {23'h0, in_svc});
   endtask : try_irq
   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test
   // Main sequence
   initial
   begin
      repeat (12) @(posedge clk);
      #1;
      nrst = 1;
      tx = 1;
      fl = 2'(rnd());
      acc(1, STAT_A, 24'hFF_FFFF);
      acc(0, STAT_A, 24'h00_0000);
      chk("status", {19'h0, fl, 1'b0, tx, rx}, rdata);
      v = 5'(rnd());
      acc(1, CTRL_A, {19'h0, v});
      acc(0, CTRL_A, 24'h00_0000);
      chk("control", {19'h0, v}, rdata & 24'h00_001F);
      acc(0, pid_pkg::IO_BASE, 24'h00_0000);
      chk("unmapped", 24'h00_0000, rdata);
      acc(0, 24'hFF_FF7F, 24'h00_0000);
      $display("test registers done");
      for (i = 0; i < 8; i++)
         try_irq(5'(i[0]), 6'(i[1]), i[2], 1, 0, 0, 0);
      $display("test gating done");
      code = 2'(rnd());
      for (i = 0; i < 3; i++)
         try_irq({code, 3'h7}, 6'h01 << (2 * i), 1, i == 0, i == 1, i == 2 ? code : ~code, i == 1);
      $display("test sources done");
      for (i = 0; i < 4; i++)
         try_irq({code, 3'h7}, i == 0 ? 6'h15 : 6'(rnd()), 1, 1, 1, code, i[0]);
      $display("test priority done");
      stop_test();
   end
   // Watchdog against a hang
   initial
   begin
      #100000;
      error_cnt++;
      stop_test();
   end
endmodule : peripheral_interrupt_dispatch_test
